// File: shared/pfc_pkg.sv
// Purpose: Shared constants for the flash control register front end
// Assumes: Byte-wide register port, one clock, synchronous reset
// Notes:   Register offsets are local to this block's port
package pfc_pkg;
  // Register index map
  localparam logic [2:0] ADDR_HIGH  = 3'h0; // Upper address byte
  localparam logic [2:0] CONTROL    = 3'h1; // Control and trigger bits
  localparam logic [2:0] UNLOCK     = 3'h2; // Unlock key, write only
  localparam logic [2:0] IRQ_STATUS = 3'h3; // Sticky events, clear on read
  localparam logic [2:0] IRQ_MASK   = 3'h4; // Interrupt enable mask

  // Control register bit positions
  localparam int BIT_READ   = 0; // Read trigger
  localparam int BIT_WRITE  = 1; // Write trigger
  localparam int BIT_ENABLE = 2; // Program unlock enable
  localparam int BIT_FAULT  = 3; // Sequence fault flag
  localparam int BIT_ERASE  = 4; // Erase select
  localparam int BIT_LATCH  = 5; // Latch only select
  localparam int BIT_CFG    = 6; // Config space select
  localparam int BIT_TOP    = 7; // Unimplemented, reads one

  // Address high field width
  localparam int ADDR_HI_W = 7;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Reset and fill values
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic       TOP_BIT   = 1'b1;

  // Interrupt status bit positions
  localparam int EV_READ_DONE  = 0; // Read finished
  localparam int EV_WRITE_DONE = 1; // Write or erase finished
  localparam int EV_FAULT      = 2; // Sequence fault raised
  localparam int EV_W          = 3; // Number of events

  // Operation timing
  localparam int READ_NS     = 5;     // One cycle read
  localparam int PROGRAM_NS  = 20000; // Programming time
  localparam int CLOCK_NS    = 5;     // 200 MHz period
  localparam int READ_CYC    = (READ_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int PROGRAM_CYC = PROGRAM_NS / CLOCK_NS;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_GOT_FIRST,
    LOCK_ARMED
  } pfc_lock_t;
endpackage : pfc_pkg

// File: rtl/pfc_op_timer.sv
// Purpose: Counts out a flash operation and pulses when it is done
// Assumes: start is a one cycle pulse while idle
// Notes:   A start while busy is ignored
`timescale 1ns/1ps
module pfc_op_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] count_q; // Cycles remaining
  logic             busy_q;  // Operation in flight
  logic             done_q;  // Completion pulse

  // Load on start, count to one, then pulse done
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_q <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && start)
      begin
        count_q <= cycles;
        busy_q  <= 1'b1;
      end
      else if (busy_q)
      begin
        if (count_q <= CNT_W'(1))
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          count_q <= count_q - CNT_W'(1);
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule : pfc_op_timer

// File: rtl/pfc_flash_ctrl.sv
// Purpose: Control register front end of the program flash sequencer
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Array itself is outside; this block issues commands only
//
// Summary of operation
// - Address high register holds bits six to zero
// - Bit seven of both registers reads one
// - Latch only: write trigger loads latch only
// - Erase select erases; hardware clears on completion
// - Erase select clear means program write
// - Fault flag set on bad sequence or trigger
// - Clear flag means last operation ended normally
// - Triggers set by software, cleared by hardware
// - Control bits reset zero; flag held at reset
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module pfc_flash_ctrl #(
  parameter int PROGRAM_CYCLES = pfc_pkg::PROGRAM_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  output logic      [6:0] flashAddressHigh,
  output logic            configSpace,
  output logic            readCmd,
  output logic            latchLoadCmd,
  output logic            programCmd,
  output logic            eraseCmd,
  output logic            opBusy,
  output logic            irq
);
  localparam int CNT_W = 16;

  // Register storage
  logic [pfc_pkg::ADDR_HI_W-1:0] addrHigh_q;  // Upper address bits
  logic                   cfgSel_q;    // Config space select
  logic                   latchOnly_q; // Latch only select
  logic                   eraseSel_q;  // Erase select
  logic                   fault_q;     // Sequence fault flag
  logic                   enable_q;    // Program unlock enable
  logic                   readTrig_q;  // Read trigger
  logic                   writeTrig_q; // Write trigger
  logic [pfc_pkg::EV_W-1:0] status_q;  // Sticky events
  logic [pfc_pkg::EV_W-1:0] mask_q;    // Event mask
  logic [7:0]             rdata_q;     // Registered read data
  pfc_pkg::pfc_lock_t     lock_q;      // Unlock sequence state
  logic [pfc_pkg::READ_CYC-1:0] readDly_q; // Read completion delay
  logic                   readCmd_q;   // Read command pulse
  logic                   latchCmd_q;  // Latch load pulse
  logic                   progCmd_q;   // Program start pulse
  logic                   eraseCmd_q;  // Erase start pulse

  // Decoded strobes
  logic wrCtl;       // Write to control
  logic wrKey;       // Write to unlock key
  logic setWrite;    // Software asks for a write
  logic goodWrite;   // Write accepted
  logic badWrite;    // Write refused
  logic startArray;  // Array operation starts
  logic opDone;      // Array operation finished
  logic timerBusy;   // Timer running
  logic readDone;    // Read finished
  logic writeDone;   // Write, erase or latch load finished

  // Register select helper
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction : hit

  assign wrCtl    = regWrite && hit(regAddr, pfc_pkg::CONTROL);
  assign wrKey    = regWrite && hit(regAddr, pfc_pkg::UNLOCK);
  assign setWrite = wrCtl && regWdata[pfc_pkg::BIT_WRITE];
  // Needs enable in the same write, armed keys, nothing in flight;
  // software sets enable and trigger together in one control write
  assign goodWrite = setWrite
                     && regWdata[pfc_pkg::BIT_ENABLE]
                     && !writeTrig_q
                     && (lock_q == pfc_pkg::LOCK_ARMED);
  assign badWrite  = setWrite && !goodWrite;
  // Latch only loads skip the array unless erasing
  assign startArray = goodWrite
                      && (regWdata[pfc_pkg::BIT_ERASE]
                          || !regWdata[pfc_pkg::BIT_LATCH]);

  // Latch only loads finish at once; array work ends on the timer
  assign writeDone = opDone || (latchCmd_q && !progCmd_q);

  // Unlock key sequence; any other write disarms it
  // A stray write between the keys must disarm, or runaway code that
  // happens to hit the key register could start a write
  always_ff @(posedge clock)
  begin
    if (rst)
      lock_q <= pfc_pkg::LOCK_IDLE;
    else if (wrKey)
    begin
      unique case (lock_q)
        pfc_pkg::LOCK_IDLE:
          lock_q <= (regWdata == pfc_pkg::KEY_FIRST)
                    ? pfc_pkg::LOCK_GOT_FIRST : pfc_pkg::LOCK_IDLE;
        pfc_pkg::LOCK_GOT_FIRST:
          lock_q <= (regWdata == pfc_pkg::KEY_SECOND)
                    ? pfc_pkg::LOCK_ARMED : pfc_pkg::LOCK_IDLE;
        pfc_pkg::LOCK_ARMED:
          lock_q <= (regWdata == pfc_pkg::KEY_FIRST)
                    ? pfc_pkg::LOCK_GOT_FIRST : pfc_pkg::LOCK_IDLE;
        default:
          lock_q <= pfc_pkg::LOCK_IDLE;
      endcase
    end
    else if (regWrite)
      lock_q <= pfc_pkg::LOCK_IDLE; // Keys must be back to back writes
  end

  // Upper address byte, bit seven not stored
  // Only seven bits exist; the top bit is made up on read
  always_ff @(posedge clock)
  begin
    if (rst)
      addrHigh_q <= '0;
    else if (regWrite && hit(regAddr, pfc_pkg::ADDR_HIGH))
      addrHigh_q <= regWdata[pfc_pkg::ADDR_HI_W-1:0];
  end

  // Plain control bits, frozen while an operation runs
  // Frozen so the bits that steer a running operation cannot shift
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cfgSel_q    <= 1'b0;
      latchOnly_q <= 1'b0;
      enable_q    <= 1'b0;
    end
    else if (wrCtl && !writeTrig_q)
    begin
      cfgSel_q    <= regWdata[pfc_pkg::BIT_CFG];
      latchOnly_q <= regWdata[pfc_pkg::BIT_LATCH];
      enable_q    <= regWdata[pfc_pkg::BIT_ENABLE];
    end
  end

  // Erase select: software writes, hardware clears after erase
  always_ff @(posedge clock)
  begin
    if (rst)
      eraseSel_q <= 1'b0;
    else if (opDone && eraseSel_q)
      eraseSel_q <= 1'b0;
    else if (wrCtl && !writeTrig_q)
      eraseSel_q <= regWdata[pfc_pkg::BIT_ERASE];
  end

  // Fault flag keeps its value through reset; set beats clear
  // Every write trigger attempt raises it; a finished operation or a control
  // write with the fault bit zero clears it, so an operation cut short by reset leaves it standing
  always_ff @(posedge clock)
  begin
    if (setWrite)
      fault_q <= 1'b1;
    else if (writeDone)
      fault_q <= 1'b0;
    else if (wrCtl)
      fault_q <= regWdata[pfc_pkg::BIT_FAULT];
  end

  // Write trigger: set only by software, cleared by hardware
  // Held through programming, else a second trigger could slip in
  // while the timer still runs and be silently dropped
  always_ff @(posedge clock)
  begin
    if (rst)
      writeTrig_q <= 1'b0;
    else if (goodWrite)
      writeTrig_q <= 1'b1;
    else if (writeDone)
      writeTrig_q <= 1'b0;
  end

  // Read trigger: a one is honoured, a zero has no effect
  // Stays up until the delayed done bit, so software never sees it
  // drop before the read data would be ready
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      readTrig_q <= 1'b0;
      readDly_q  <= '0;
    end
    else
    begin
      readDly_q <= {readDly_q[pfc_pkg::READ_CYC-1:0] << 1}
                   | pfc_pkg::READ_CYC'(readCmd_q);
      if (wrCtl && regWdata[pfc_pkg::BIT_READ] && !readTrig_q)
        readTrig_q <= 1'b1;
      else if (readDone)
        readTrig_q <= 1'b0;
    end
  end
  assign readDone = readDly_q[pfc_pkg::READ_CYC-1];

  // Command pulses toward the array
  // Taken from the write data, so the choice made in the same write
  // as the trigger is the one honoured
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      readCmd_q  <= 1'b0;
      latchCmd_q <= 1'b0;
      progCmd_q  <= 1'b0;
      eraseCmd_q <= 1'b0;
    end
    else
    begin
      readCmd_q  <= wrCtl && regWdata[pfc_pkg::BIT_READ] && !readTrig_q;
      // Every accepted write that is not an erase loads the addressed latch
      latchCmd_q <= goodWrite && !regWdata[pfc_pkg::BIT_ERASE];
      progCmd_q  <= startArray && !regWdata[pfc_pkg::BIT_ERASE];
      eraseCmd_q <= startArray && regWdata[pfc_pkg::BIT_ERASE];
    end
  end

  // Self timed array operation
  // One timer serves program and erase; a latch only load never
  // starts it
  pfc_op_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clock  (clock),
    .rst    (rst),
    .start  (progCmd_q || eraseCmd_q),
    .cycles (CNT_W'(PROGRAM_CYCLES)),
    .busy   (timerBusy),
    .done   (opDone)
  );

  // Sticky events; a read of status clears, a new event wins
  // Write, erase and latch load completions share one bit to keep the map small
  always_ff @(posedge clock)
  begin
    if (rst)
      status_q <= '0;
    else
    begin
      if (regRead && hit(regAddr, pfc_pkg::IRQ_STATUS))
        status_q <= '0;
      if (readDone)
        status_q[pfc_pkg::EV_READ_DONE] <= 1'b1;
      if (writeDone)
        status_q[pfc_pkg::EV_WRITE_DONE] <= 1'b1;
      if (badWrite)
        status_q[pfc_pkg::EV_FAULT] <= 1'b1;
    end
  end

  // Interrupt mask
  // Mask bits line up one to one with the status bits
  always_ff @(posedge clock)
  begin
    if (rst)
      mask_q <= '0;
    else if (regWrite && hit(regAddr, pfc_pkg::IRQ_MASK))
      mask_q <= regWdata[pfc_pkg::EV_W-1:0];
  end

  // Read data, valid only in the cycle after the strobe
  // Zero outside reads keeps the bus quiet when results are ORed
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_q <= pfc_pkg::ZERO_BYTE;
    else if (!regRead)
      rdata_q <= pfc_pkg::ZERO_BYTE;
    else
    begin
      unique case (regAddr)
        pfc_pkg::ADDR_HIGH:
          rdata_q <= {pfc_pkg::TOP_BIT, addrHigh_q};
        pfc_pkg::CONTROL:
          rdata_q <= {pfc_pkg::TOP_BIT, cfgSel_q, latchOnly_q,
                      eraseSel_q, fault_q, enable_q, writeTrig_q,
                      readTrig_q};
        pfc_pkg::IRQ_STATUS:
          rdata_q <= {{(8-pfc_pkg::EV_W){1'b0}}, status_q};
        pfc_pkg::IRQ_MASK:
          rdata_q <= {{(8-pfc_pkg::EV_W){1'b0}}, mask_q};
        default:
          rdata_q <= pfc_pkg::ZERO_BYTE; // Unlock key and holes read zero
      endcase
    end
  end

  // Outputs
  assign regRdata         = rdata_q;
  assign flashAddressHigh = addrHigh_q;
  assign configSpace      = cfgSel_q;
  assign readCmd          = readCmd_q;
  assign latchLoadCmd     = latchCmd_q;
  assign programCmd       = progCmd_q;
  assign eraseCmd         = eraseCmd_q;
  assign opBusy           = timerBusy || writeTrig_q;
  assign irq              = |(status_q & mask_q);
endmodule : pfc_flash_ctrl

// File: sim/pfc_flash_ctrl_props.sv
// Purpose: Port-level checks for the flash control front end
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto every pfc_flash_ctrl instance
`timescale 1ns/1ps
module pfc_flash_ctrl_props #(
  parameter int PROGRAM_CYCLES = pfc_pkg::PROGRAM_CYC
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic [6:0] flashAddressHigh,
  input wire logic       readCmd,
  input wire logic       latchLoadCmd,
  input wire logic       programCmd,
  input wire logic       eraseCmd,
  input wire logic       opBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  int busyCnt_q; // Cycles of busy in a row

  // Busy run length; a stuck trigger shows up here
  always_ff @(posedge clock)
  begin
    if (rst || !opBusy)
      busyCnt_q <= 0;
    else
      busyCnt_q <= busyCnt_q + 1;
  end

  // Both keys on consecutive writes, then a control write while idle
  sequence unlocked(logic [7:0] c);
    regWrite && regAddr == 3'h2 && regWdata == 8'h55
    ##1 regWrite && regAddr == 3'h2 && regWdata == 8'hAA
    ##1 regWrite && regAddr == 3'h1 && regWdata == c && !opBusy;
  endsequence

  chk_addr_hold: assert property (
    regWrite && regAddr == 3'h0 |=>
    flashAddressHigh == $past(regWdata[6:0]))
    else $error("address high not stored");
  chk_top_one: assert property (
    regRead && regAddr < 3'h2 |=> regRdata[7])
    else $error("bit seven not one");
  chk_rdata_idle: assert property (
    !regRead |=> regRdata == 8'h00) else $error("stray read data");
  chk_prog_start: assert property (
    unlocked(8'h06) |=> latchLoadCmd && programCmd && !eraseCmd)
    else $error("program not started");
  chk_latch_only: assert property (
    unlocked(8'h26) |=> latchLoadCmd && !programCmd && !eraseCmd)
    else $error("latch only misbehaved");
  chk_erase_start: assert property (
    unlocked(8'h36) |=> eraseCmd && !latchLoadCmd && !programCmd)
    else $error("erase not started");
  chk_no_enable: assert property (
    regWrite && regAddr == 3'h1 && regWdata[1] && !regWdata[2] |=>
    !(programCmd || eraseCmd || latchLoadCmd))
    else $error("start without enable");
  chk_read_pulse: assert property (
    regWrite && regAddr == 3'h1 && regWdata[0] && !readCmd
    && !$past(readCmd) |=> readCmd ##1 !readCmd)
    else $error("read pulse wrong");
  chk_busy_bound: assert property (
    busyCnt_q <= PROGRAM_CYCLES + 4) else $error("trigger never cleared");
endmodule : pfc_flash_ctrl_props

bind pfc_flash_ctrl pfc_flash_ctrl_props #(
  .PROGRAM_CYCLES(PROGRAM_CYCLES)
) chk_u (.clock, .rst, .regAddr, .regWdata, .regWrite, .regRead,
  .regRdata, .flashAddressHigh, .readCmd, .latchLoadCmd, .programCmd,
  .eraseCmd, .opBusy);

// File: sim/pfc_flash_ctrl_bench.sv
// Purpose: Self-checking bench for the flash control front end
// Assumes: Register port driven by NBA right after rising edges
// Notes:   Short program time keeps each operation to a few cycles
`timescale 1ns/1ps
module pfc_flash_ctrl_bench;
  logic       clock, rst, regWrite, regRead;  // Clock, reset, strobes
  logic [2:0] regAddr;                        // Register index
  logic [7:0] regWdata, regRdata, rv;         // Data, last read value
  logic       configSpace, readCmd, latchLoadCmd, programCmd;
  logic       eraseCmd, opBusy, irq;          // Status outputs
  logic [6:0] flashAddressHigh;               // Upper address bits
  int         mismatches, checked;            // Verdict counters

  pfc_flash_ctrl #(.PROGRAM_CYCLES(10)) dut_u (.clock, .rst, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .flashAddressHigh,
    .configSpace, .readCmd, .latchLoadCmd, .programCmd, .eraseCmd,
    .opBusy, .irq);

  // Free-running 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // One counted comparison
  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  // Strobe held up so writes may run back to back
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
  endtask : wr

  // Data is only valid the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regRead  <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // Drop the write strobe, look just after the taking edge
  task automatic settle;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask : settle

  // Keys, control write, then the command pulses
  task automatic launch(input logic [7:0] k, input logic [7:0] c,
                        input logic [2:0] e);
    wr(3'h2, k);
    wr(3'h2, 8'hAA);
    wr(3'h1, c);
    settle();
    cmp("cmds", {5'h00, e}, {5'h00, latchLoadCmd, programCmd, eraseCmd});
  endtask : launch

  // Bounded wait for the operation to finish
  task automatic done;
    for (int i = 0; i < 40 && opBusy !== 1'b0; i++)
    begin
      @(posedge clock);
      #1;
    end
    cmp("busy", 8'h00, {7'h00, opBusy});
  endtask : done

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Run takes under 400 cycles; 4000 means a hang
  initial
  begin
    #20000;
    mismatches++;
    test_done();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    mismatches = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    // Fault flag is unknown after power-up, so it is masked
    for (int i = 0; i < 6; i++)
    begin
      rd(3'(i), rv);
      cmp("reset", i < 2 ? 8'h80 : 8'h00, rv & 8'hF7);
    end
    $display("test reset done");
    wr(3'h0, 8'hFF);
    rd(3'h0, rv);
    cmp("addr ff", 8'hFF, rv);
    wr(3'h0, 8'h2A);
    rd(3'h0, rv);
    cmp("addr", 8'hAA, rv);
    cmp("addr pin", 8'h2A, {1'b0, flashAddressHigh});
    wr(3'h1, 8'h40);
    settle();
    cmp("cfg on", 8'h01, {7'h00, configSpace});
    wr(3'h1, 8'h00);
    settle();
    cmp("cfg off", 8'h00, {7'h00, configSpace});
    $display("test registers done");
    // Masked refusal: event recorded, no interrupt
    wr(3'h4, 8'h00);
    launch(8'hAA, 8'h06, 3'b000);
    cmp("irq masked", 8'h00, {7'h00, irq});
    rd(3'h1, rv);
    cmp("fault", 8'h08, rv & 8'h08);
    rd(3'h3, rv);
    cmp("status", 8'h04, rv);
    rd(3'h3, rv);
    cmp("status clr", 8'h00, rv);
    wr(3'h4, 8'h07);
    launch(8'h55, 8'h02, 3'b000);
    cmp("irq", 8'h01, {7'h00, irq});
    rd(3'h3, rv);
    cmp("status", 8'h04, rv);
    $display("test refusal done");
    launch(8'h55, 8'h06, 3'b110);
    rd(3'h1, rv);
    cmp("ctl busy", 8'h8E, rv);
    done();
    cmp("irq", 8'h01, {7'h00, irq});
    rd(3'h3, rv);
    cmp("status", 8'h02, rv);
    rd(3'h1, rv);
    cmp("ctl idle", 8'h84, rv);
    launch(8'h55, 8'h26, 3'b100);
    done();
    rd(3'h1, rv);
    cmp("ctl latch", 8'hA4, rv);
    launch(8'h55, 8'h36, 3'b001);
    done();
    rd(3'h1, rv);
    cmp("ctl erase", 8'hA4, rv);
    rd(3'h3, rv);
    cmp("status", 8'h02, rv);
    $display("test operations done");
    wr(3'h1, 8'h81);
    settle();
    cmp("read cmd", 8'h01, {7'h00, readCmd});
    settle();
    cmp("read once", 8'h00, {7'h00, readCmd});
    rd(3'h1, rv);
    cmp("ctl read", 8'h80, rv);
    rd(3'h3, rv);
    cmp("status", 8'h01, rv);
    $display("test read done");
    test_done();
  end
endmodule : pfc_flash_ctrl_bench
